/* csgd_top.sv */
// csgd_top: source select, glitch-free output gate and divide-by-two for a clock fan-out.
// Assumes ref_clk oversamples both input pairs well above their rate; sys_rst is the master clear.
`timescale 1ns/1ps
module csgd_top
	import csgd_pkg::*;
(
	input  wire logic  ref_clk,               // sampling clock
	input  wire logic  sys_rst,               // master clear, async, active high
	input  wire logic  primary_input_pos,     // primary pair, true leg
	input  wire logic  primary_input_neg,     // primary pair, complement leg
	input  wire logic  alternate_input_pos,   // alternate pair, true leg
	input  wire logic  alternate_input_neg,   // alternate pair, complement leg
	input  wire logic  source_select,         // low primary, high alternate
	input  wire logic  output_gate_enable,    // high lets outputs run
	output logic       full_rate_out0,
	output logic       full_rate_out0_neg,
	output logic       full_rate_out1,
	output logic       full_rate_out1_neg,
	output logic       half_rate_out0,
	output logic       half_rate_out0_neg,
	output logic       half_rate_out1,
	output logic       half_rate_out1_neg
);

	logic [PIN_COUNT-1:0] pins_s;     // synchronised pins
	csgd_state_t          state_ff;   // registered state
	csgd_state_t          nxt_state;  // next state
	logic                 pri_lvl;    // decoded primary level
	logic                 alt_lvl;    // decoded alternate level
	logic                 sel_lvl;    // level of the chosen source
	logic                 rise;       // rising edge of chosen source
	logic                 fall;       // falling edge of chosen source
	logic                 gate_en;    // synchronised gate control
	logic                 running;    // outputs enabled in next state

	// all pins pass two flip-flops before decoding
	csgd_sync #(
		.WIDTH  (PIN_COUNT),
		.STAGES (SYNC_STAGES)
	) u_sync (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.async_in ({output_gate_enable, source_select, alternate_input_neg,
		            alternate_input_pos, primary_input_neg, primary_input_pos}),
		.sync_out (pins_s)
	);

	// differential decode: high only when legs disagree the right way
	function automatic logic diff_level(input logic p, input logic n);
		diff_level = p & ~n;
	endfunction

	// build a bank from run flag and source bit
	function automatic csgd_bank_t drive_bank(input logic run, input logic src);
		drive_bank.pos = {NUM_PAIRS{run & src}};
		drive_bank.neg = ~{NUM_PAIRS{run & src}};
	endfunction

	// source mux and edge detection
	always_comb begin
		pri_lvl = diff_level(pins_s[PIN_PRI_POS], pins_s[PIN_PRI_NEG]);
		alt_lvl = diff_level(pins_s[PIN_ALT_POS], pins_s[PIN_ALT_NEG]);
		sel_lvl = (pins_s[PIN_SEL] == SEL_ALTERNATE) ? alt_lvl : pri_lvl;   // see [RQ1]
		rise    = sel_lvl & ~state_ff.clk_lvl;
		fall    = ~sel_lvl & state_ff.clk_lvl;
		gate_en = pins_s[PIN_GATE];                                         // see [RQ3]
	end

	// gate sequencer, divider and output registers
	always_comb begin
		nxt_state         = state_ff;
		nxt_state.clk_lvl = sel_lvl;
		case (state_ff.gate)
			GATE_OFF: begin
				// wait for enable plus a rising edge
				if (gate_en && rise) begin
					nxt_state.gate = GATE_ARM_ON;                           // see [RQ4]
				end
			end
			GATE_ARM_ON: begin
				// enable withdrawn before the fall: abandon
				if (!gate_en) begin
					nxt_state.gate = GATE_OFF;
				end else if (fall) begin
					nxt_state.gate = GATE_ON;                               // see [RQ4]
				end
			end
			GATE_ON: begin
				// disable only counts from a rise onward, so a high phase is never cut
				if (!gate_en && rise) begin
					nxt_state.gate = GATE_ARM_OFF;                          // see [RQ4]
				end
			end
			GATE_ARM_OFF: begin
				// stop only on a fall with the half-rate leg low, so no bank is cut short
				if (gate_en) begin
					nxt_state.gate = GATE_ON;
				end else if (fall && !state_ff.div) begin
					nxt_state.gate = GATE_OFF;                              // see [RQ3]
				end
			end
			default: begin
				// unused encodings park the outputs rather than guess a phase
				nxt_state.gate = GATE_OFF;
			end
		endcase
		running = (nxt_state.gate == GATE_ON) || (nxt_state.gate == GATE_ARM_OFF);
		// divider runs only while enabled, parked low so restart phase is known
		if (!running) begin
			nxt_state.div = DIV_RESET;                                      // see [RQ9]
		end else if (rise) begin
			nxt_state.div = ~state_ff.div;                                  // see [RQ2]
		end
		// outputs depend only on chosen clock while running
		nxt_state.full = drive_bank(running, sel_lvl);                      // see [RQ2] [RQ6] [RQ8]
		nxt_state.half = drive_bank(running, nxt_state.div);                // see [RQ5] [RQ6]
	end

	// master clear parks everything and clears the divider
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= '{clk_lvl: 1'h0, gate: GATE_OFF, div: DIV_RESET,
			              full: BANK_IDLE, half: BANK_IDLE};                 // see [RQ7] [RQ9]
		end else begin
			state_ff <= nxt_state;
		end
	end

	// outputs taken straight from registers
	assign full_rate_out0     = state_ff.full.pos[0];
	assign full_rate_out1     = state_ff.full.pos[1];
	assign full_rate_out0_neg = state_ff.full.neg[0];
	assign full_rate_out1_neg = state_ff.full.neg[1];
	assign half_rate_out0     = state_ff.half.pos[0];
	assign half_rate_out1     = state_ff.half.pos[1];
	assign half_rate_out0_neg = state_ff.half.neg[0];
	assign half_rate_out1_neg = state_ff.half.neg[1];

	// checks on the gate, divider and output banks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	logic gated_ff;   // registered banks are running
	assign gated_ff = (state_ff.gate == GATE_ON) || (state_ff.gate == GATE_ARM_OFF);

	// registered full leg is last cycle's chosen level
	AST_SELECT_SOURCE: assert property ( // see [RQ1]
		gated_ff |-> full_rate_out0 == $past(pins_s[PIN_SEL] ? alt_lvl : pri_lvl))
		else $error("full-rate output does not follow the selected source");

	// three complement legs mirror their true legs; second full true leg matches the first
	AST_COMP_PAIRS: assert property ( // see [RQ2]
		(full_rate_out0_neg == ~full_rate_out0) && (full_rate_out1 == full_rate_out0) &&
		(half_rate_out0_neg == ~half_rate_out0) && (half_rate_out1_neg == ~half_rate_out1))
		else $error("output pair legs disagree");

	// half leg may only move on a source rise
	AST_HALF_ON_RISE: assert property ( // see [RQ2]
		$changed(half_rate_out0) && $past(gated_ff) && gated_ff |-> $rose(state_ff.clk_lvl))
		else $error("half-rate output moved without a rising source edge");

	// a full-rate fall must coincide with a low source
	AST_NO_RUNT_FALL: assert property ( // see [RQ3]
		$fell(full_rate_out0) |-> !state_ff.clk_lvl)
		else $error("full-rate output cut while source high");

	// enable lands only on the fall after an armed rise
	AST_ON_AFTER_RISE_FALL: assert property ( // see [RQ4]
		$rose(gated_ff) |-> $past(state_ff.gate) == GATE_ARM_ON && !state_ff.clk_lvl && $past(gate_en))
		else $error("outputs enabled without rise then fall");

	// gated off: every leg at its idle level
	AST_OFF_IDLE: assert property ( // see [RQ5]
		!gated_ff |-> !full_rate_out0 && !full_rate_out1 && full_rate_out0_neg && full_rate_out1_neg &&
		              !half_rate_out0 && !half_rate_out1 && half_rate_out0_neg && half_rate_out1_neg)
		else $error("outputs not idle while gated off");

	// a high gate never stops running outputs
	AST_STAYS_ON: assert property ( // see [RQ6]
		gated_ff && gate_en |=> gated_ff)
		else $error("outputs stopped while gate control high");

	// master clear parks outputs whatever the gate and select do
	AST_CLEAR_IDLE: assert property (@(posedge ref_clk) disable iff (1'b0) // see [RQ7]
		sys_rst |-> !full_rate_out0 && full_rate_out0_neg && !half_rate_out1 && half_rate_out1_neg)
		else $error("outputs not idle under master clear");

	// divider held at its restart phase while off
	AST_DIV_PARKED: assert property ( // see [RQ9]
		!gated_ff |-> state_ff.div == DIV_RESET)
		else $error("divider not parked while gated off");

	// arming entered only with the gate high on a source rise
	AST_ARM_ON_RISE: assert property ( // see [RQ4]
		state_ff.gate == GATE_ARM_ON && $past(state_ff.gate) == GATE_OFF |->
		$rose(state_ff.clk_lvl) && $past(gate_en))
		else $error("arming entered without a rising source edge");

	// stop only on a fall with the half leg low, so no pulse is shortened
	AST_OFF_SAFE_FALL: assert property ( // see [RQ3]
		$fell(gated_ff) |-> $past(state_ff.gate) == GATE_ARM_OFF && $fell(state_ff.clk_lvl) &&
		                    !$past(gate_en) && !$past(state_ff.div))
		else $error("outputs stopped away from a safe falling edge");

	// half leg toggles on every source rise while running
	AST_HALF_TOGGLES: assert property ( // see [RQ2]
		gated_ff && $past(gated_ff) && $rose(state_ff.clk_lvl) |-> $changed(half_rate_out0))
		else $error("half-rate output missed a rising source edge");

	// second half pair matches the first; second full complement mirrors its true leg
	AST_SECOND_LEGS: assert property ( // see [RQ2]
		(half_rate_out1 == half_rate_out0) && (full_rate_out1_neg == ~full_rate_out1))
		else $error("second output pair differs from the first");

	// every enable starts both banks low, from a known divider phase
	AST_RESTART_PHASE: assert property ( // see [RQ9]
		$rose(gated_ff) |-> !half_rate_out0 && !full_rate_out0)
		else $error("outputs enabled with a stale divider phase");

	COV_ENABLE: cover property ($rose(gated_ff));
	COV_DISABLE: cover property ($fell(gated_ff));
	COV_HALF_RUN: cover property ($rose(half_rate_out0) ##[1:40] $fell(half_rate_out0));
	COV_ALT_RUN: cover property (gated_ff && pins_s[PIN_SEL] && $rose(full_rate_out0));

endmodule

/* csgd_pkg.sv */
// csgd_pkg: shared constants, state enum and state record of the clock select/gate/divide block.
// Assumes a single ref_clk domain; every clock pin is oversampled and synchronised in that domain.
// What this block does
// [RQ1] Select input picks primary (low) or alternate (high).
// [RQ2] Two full-rate pairs, two half-rate pairs.
// [RQ3] Gate control synchronised, never produces runt pulses.
// [RQ4] Gate change applied after rise, then fall.
// [RQ5] Gated off: true outputs low, complements high.
// [RQ6] Gated on: outputs follow source at ratios.
// [RQ7] Master clear forces true low, complement high.
// [RQ8] Active outputs depend only on selected clock.
// [RQ9] Master clear async high, also clears divider.
package csgd_pkg;

	// reference clock figures
	localparam int unsigned REF_CLK_PERIOD_NS = 100;     // 10 MHz sampling clock
	localparam int unsigned SYNC_STAGES       = 2;       // flip-flops ahead of any logic
	localparam int unsigned NUM_PAIRS         = 2;       // pairs per rate bank

	// source select encoding
	localparam logic        SEL_PRIMARY       = 1'h0;    // low picks the primary pair
	localparam logic        SEL_ALTERNATE     = 1'h1;    // high picks the alternate pair

	// idle levels of the outputs
	localparam logic        IDLE_TRUE         = 1'h0;    // true outputs rest low
	localparam logic        IDLE_COMP         = 1'h1;    // complement outputs rest high
	localparam logic        DIV_RESET         = 1'h0;    // divider phase after clear

	// bit positions in the synchronised input vector
	localparam int unsigned PIN_PRI_POS       = 0;
	localparam int unsigned PIN_PRI_NEG       = 1;
	localparam int unsigned PIN_ALT_POS       = 2;
	localparam int unsigned PIN_ALT_NEG       = 3;
	localparam int unsigned PIN_SEL           = 4;
	localparam int unsigned PIN_GATE          = 5;
	localparam int unsigned PIN_COUNT         = 6;

	// gate sequencer, gray along off -> arming -> on -> disarming -> off
	typedef enum logic [1:0] {
		GATE_OFF     = 2'h0,   // outputs parked
		GATE_ARM_ON  = 2'h1,   // enable seen plus rising edge, awaiting fall
		GATE_ON      = 2'h3,   // outputs running
		GATE_ARM_OFF = 2'h2    // disable seen plus rising edge, awaiting safe fall
	} csgd_gate_t;

	// one output bank: true and complement per pair
	typedef struct packed {
		logic [NUM_PAIRS-1:0] pos;   // true outputs
		logic [NUM_PAIRS-1:0] neg;   // complement outputs
	} csgd_bank_t;

	// whole state of the top module
	typedef struct packed {
		logic       clk_lvl;   // selected clock level, one cycle old
		csgd_gate_t gate;      // gate sequencer
		logic       div;       // divide-by-two phase
		csgd_bank_t full;      // full-rate bank registers
		csgd_bank_t half;      // half-rate bank registers
	} csgd_state_t;

	localparam csgd_bank_t BANK_IDLE = '{pos: {NUM_PAIRS{IDLE_TRUE}}, neg: {NUM_PAIRS{IDLE_COMP}}};

endpackage

/* csgd_sync.sv */
// csgd_sync: plain multi-stage synchroniser for a vector of asynchronous pins.
// Assumes each bit is independent; no bus coherence across bits is promised.
`timescale 1ns/1ps
module csgd_sync
	import csgd_pkg::*;
#(
	parameter int unsigned WIDTH  = PIN_COUNT,
	parameter int unsigned STAGES = SYNC_STAGES
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// chain of stages; stage 0 is read only by stage 1
	typedef logic [STAGES-1:0][WIDTH-1:0] csgd_chain_t;

	csgd_chain_t chain_ff;   // registered chain
	csgd_chain_t nxt_chain;  // next chain value

	// shift the pins one stage further each edge
	always_comb begin
		nxt_chain = {chain_ff[STAGES-2:0], async_in};
	end

	// reset to zero, pins settle within STAGES edges of release
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chain_ff <= '0;
		end else begin
			chain_ff <= nxt_chain;
		end
	end

	assign sync_out = chain_ff[STAGES-1];

endmodule

/* csgd_src_model.sv */
// csgd_src_model: free-running differential sources for both input pairs.
// Assumes ref_clk is the bench clock; every leg moves 1 ns after its rise.
`timescale 1ns/1ps
module csgd_src_model #(
	parameter int HP_PRI = 4,   // primary half period, ref_clk cycles
	parameter int HP_ALT = 3    // alternate half period, differs to tell pairs apart
) (
	input  wire logic ref_clk,
	output logic      pri_pos,
	output logic      pri_neg,
	output logic      alt_pos,
	output logic      alt_neg
);
	int pri_cnt = 0;   // cycles spent in current primary phase
	int alt_cnt = 0;   // cycles spent in current alternate phase
	// legs kept complementary, so a pair never decodes as pos==neg
	initial begin
		pri_pos = 1'h0;
		alt_pos = 1'h0;
	end
	assign pri_neg = ~pri_pos;
	assign alt_neg = ~alt_pos;
	// both sources run free; input clocks do not stop between uses
	always @(posedge ref_clk) begin
		#1;
		pri_cnt = pri_cnt + 1;
		alt_cnt = alt_cnt + 1;
		if (pri_cnt == HP_PRI) begin
			pri_cnt = 0;
			pri_pos = ~pri_pos;
		end
		if (alt_cnt == HP_ALT) begin
			alt_cnt = 0;
			alt_pos = ~alt_pos;
		end
	end
endmodule

/* csgd_tb.sv */
// tb: self-checking bench for csgd_top, with csgd_src_model on the clock pins.
// Assumes csgd_pkg is compiled first; all pins change 1 ns after ref_clk rises.
`timescale 1ns/1ps
module tb;
	import csgd_pkg::*;
	localparam int HPP = 4;                         // primary half period
	localparam int HPA = 3;                         // alternate half period
	logic       ref_clk, sys_rst, sel, gate;        // bench-driven pins
	logic       pri_pos, pri_neg, alt_pos, alt_neg; // source legs
	logic       f0, f0n, f1, f1n, h0, h0n, h1, h1n; // output legs
	logic [7:0] outs;                               // all outputs packed
	int         fail_count = 0;
	int         n_compared = 0;
	logic       follow = 1'h0;                      // running, so full must track pin
	logic [3:0] hist = '0;                          // selected pin history, newest bit 0
	logic       pf = 1'h0;                          // previous full level
	logic       ph = 1'h0;                          // previous half level
	int         full_hi = 0;                        // current full high run
	int         half_hi = 0;                        // current half high run
	assign outs = {h1n, h1, h0n, h0, f1n, f1, f0n, f0};
	// clock source, free running
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	csgd_src_model #(.HP_PRI(HPP), .HP_ALT(HPA)) src_u (.ref_clk(ref_clk), .pri_pos(pri_pos), .pri_neg(pri_neg),
		.alt_pos(alt_pos), .alt_neg(alt_neg));
	csgd_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .primary_input_pos(pri_pos), .primary_input_neg(pri_neg),
		.alternate_input_pos(alt_pos), .alternate_input_neg(alt_neg), .source_select(sel),
		.output_gate_enable(gate), .full_rate_out0(f0), .full_rate_out0_neg(f0n), .full_rate_out1(f1),
		.full_rate_out1_neg(f1n), .half_rate_out0(h0), .half_rate_out0_neg(h0n), .half_rate_out1(h1),
		.half_rate_out1_neg(h1n));
	function automatic logic sel_pin();
		return sel ? (alt_pos & ~alt_neg) : (pri_pos & ~pri_neg);
	endfunction
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// a wait that ran out is a mismatch and ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			fail_count++;
			$display("MISMATCH wait expected done seen timeout");
			test_done();
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// watcher at the falling edge, where outputs are settled; skipped while cleared
	always @(negedge ref_clk) begin
		if (!sys_rst) begin
			chk("pairs", 8'({f1, f1n, h1, h1n}), 8'({f0, ~f0, h0, ~h0}));
			// full leg trails the pin by two synchroniser edges and one output edge
			if (follow) chk("full", 8'(f0), 8'(hist[2]));
			chk("half_toggle", 8'(h0 != ph), 8'(f0 && !pf));
			if (pf && !f0) chk("full_hi", 8'(full_hi), 8'(sel ? HPA : HPP));
			if (ph && !h0) chk("half_hi", 8'(half_hi), 8'(sel ? 2 * HPA : 2 * HPP));
		end
		full_hi = f0 ? full_hi + 1 : 0;
		half_hi = h0 ? half_hi + 1 : 0;
		pf = f0;
		ph = h0;
		hist = {hist[2:0], sel_pin()};
	end
	// gated off: outputs parked whichever source is picked
	task automatic t_gated_off();
		for (int s = 0; s < 2; s++) begin
			sel = s[0];
			repeat (24) begin
				step(1);
				chk("off_idle", outs, 8'haa);
			end
		end
		$display("test gated_off done");
	endtask
	// enable right after a source fall, run, then drop the gate mid-stream
	task automatic t_run(input logic s);
		int n;
		int hp;
		hp = s ? HPA : HPP;
		sel = s;
		step(8);
		// fall judged from the falling-edge history, so the source's own step never races this read
		for (n = 0; n < 40 && !(hist[0] === 1'h0 && hist[1] === 1'h1); n++) step(1);
		bound(n, 40);
		gate = 1'h1;
		for (n = 0; n < 60 && f0 !== 1'h1; n++) step(1);
		bound(n, 60);
		// rise, fall, rise of the source plus sync and output edges, counted from the edge after the fall
		chk("en_latency", 8'(n), 8'(3 * hp + 2));
		follow = 1'h1;
		step(10 * hp + 1);
		gate = 1'h0;
		follow = 1'h0;
		step(8 * hp + 6);
		repeat (4 * hp) begin
			step(1);
			chk("dis_idle", outs, 8'haa);
		end
		$display("test run %0d done", s);
	endtask
	// master clear in mid-pulse, then restart phase
	task automatic t_clear();
		int n;
		sel = 1'h0;
		gate = 1'h1;
		for (n = 0; n < 60 && f0 !== 1'h1; n++) step(1);
		bound(n, 60);
		step(1);
		sys_rst = 1'h1;
		#1;
		chk("clr_now", outs, 8'haa);
		repeat (3) begin
			step(1);
			chk("clr_hold", outs, 8'haa);
		end
		sys_rst = 1'h0;
		for (n = 0; n < 60 && f0 !== 1'h1; n++) step(1);
		bound(n, 60);
		chk("clr_phase", 8'(h0), 8'h01);
		follow = 1'h1;
		step(20);
		gate = 1'h0;
		follow = 1'h0;
		step(8 * HPP + 6);
		$display("test clear done");
	endtask
	initial begin
		// clear rises just after time zero so every reset process is waiting for its edge
		sys_rst = 1'h0;
		sel = 1'h0;
		gate = 1'h1;
		#1;
		sys_rst = 1'h1;
		for (int i = 0; i < 8; i++) begin
			step(1);
			sel = i[0];
			chk("rst_idle", outs, 8'haa);
		end
		sys_rst = 1'h0;
		gate = 1'h0;
		$display("test reset done");
		t_gated_off();
		t_run(1'h0);
		t_run(1'h1);
		t_clear();
		test_done();
	end
endmodule
